// ---- inc/rwb_pkg.sv ----
// Constants shared by the read/write buffer design
package rwb_pkg;
  localparam int RWB_WIDTH = 18;
  localparam int RWB_DEPTH = 4;
  localparam int RWB_WRITE_TO_B_CLOCKS = 4;
  localparam logic RWB_FULL_N_RESET = 1'h1;
  localparam logic RWB_OE_RESET = 1'h0;
endpackage

// ---- core/rwb_top.sv ----
// Read/write buffer: write-path FIFO and registered read-back path

// --------------------------------------------------------------------
// Write-path FIFO
// --------------------------------------------------------------------
module rwb_fifo
  import rwb_pkg::*;
#(
  parameter int WIDTH = RWB_WIDTH,
  parameter int DEPTH = RWB_DEPTH
) (
  // Clock and synchronous reset
  input wire logic clk_i,
  input wire logic sync_resetn_i,
  // Fill side
  input wire logic wr_valid_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  output logic wr_ready_o,
  // Drain side
  input wire logic rd_ready_i,
  output logic rd_valid_o,
  output logic [WIDTH-1:0] rd_data_o,
  // Status
  output logic full_n_o,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("rwb_fifo: DEPTH must be a power of two, at least 2");
    end
    if (WIDTH < 1) begin : g_bad_width
      $error("rwb_fifo: WIDTH must be positive");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_count;
  logic do_wr;
  logic do_rd;

  // Full wins over a write, empty wins over a read
  assign wr_ready_o = (count_o != (AW+1)'(DEPTH));
  assign rd_valid_o = (count_o != '0);
  assign do_wr = wr_valid_i && wr_ready_o;
  assign do_rd = rd_ready_i && rd_valid_o;
  assign count_o = wr_ptr - rd_ptr;

  always_comb begin
    next_count = count_o;
    if (do_wr && !do_rd) begin
      next_count = count_o + 1'h1;
    end else if (do_rd && !do_wr) begin
      next_count = count_o - 1'h1;
    end
  end

  // Reset is sampled on the edge only, never asynchronously
  always_ff @(posedge clk_i) begin
    if (!sync_resetn_i) begin
      wr_ptr <= '0;
    end else if (do_wr) begin
      wr_ptr <= wr_ptr + 1'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!sync_resetn_i) begin
      rd_ptr <= '0;
    end else if (do_rd) begin
      rd_ptr <= rd_ptr + 1'h1;
    end
  end

  // Storage is not cleared by reset; pointers alone define contents
  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= wr_data_i;
    end
  end

  // Output register holds the last word read when nothing new comes
  always_ff @(posedge clk_i) begin
    if (!sync_resetn_i) begin
      rd_data_o <= '1;
    end else if (do_rd) begin
      rd_data_o <= mem[rd_ptr[AW-1:0]];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!sync_resetn_i) begin
      full_n_o <= RWB_FULL_N_RESET;
    end else begin
      full_n_o <= (next_count != (AW+1)'(DEPTH));
    end
  end
endmodule

module rwb_top
  import rwb_pkg::*;
#(
  parameter int WIDTH = RWB_WIDTH,
  parameter int DEPTH = RWB_DEPTH
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Write-path control
  input wire logic fifo_write_enable_n_i,
  input wire logic fifo_read_enable_n_i,
  output logic fifo_full_n_o,
  // Read-back control
  input wire logic readback_capture_enable_n_i,
  // Output enables
  input wire logic a_drive_enable_n_i,
  input wire logic b_drive_enable_n_i,
  // Host side port
  input wire logic [WIDTH-1:0] host_side_port_i,
  output logic [WIDTH-1:0] host_side_port_o,
  output logic host_side_port_oe_o,
  // Memory side port
  input wire logic [WIDTH-1:0] memory_side_port_i,
  output logic [WIDTH-1:0] memory_side_port_o,
  output logic memory_side_port_oe_o
);
  localparam int AW = $clog2(DEPTH);

  logic [$clog2(DEPTH):0] fifo_count;
  logic [WIDTH-1:0] fifo_out;
  logic fifo_full_n;

  // --------------------------------------------------------------------
  // Write path
  // --------------------------------------------------------------------
  // No read-back signal reaches the FIFO
  rwb_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_i(core_clk_i),
    .sync_resetn_i(resetn_i),
    .wr_valid_i(!fifo_write_enable_n_i),
    .wr_data_i(host_side_port_i),
    .wr_ready_o(),
    .rd_ready_i(!fifo_read_enable_n_i),
    .rd_valid_o(),
    .rd_data_o(fifo_out),
    .full_n_o(fifo_full_n),
    .count_o(fifo_count)
  );

  assign fifo_full_n_o = fifo_full_n;
  assign memory_side_port_o = fifo_out;

  // --------------------------------------------------------------------
  // Read-back path
  // --------------------------------------------------------------------
  // Register only: breaking the B-to-A combinational path costs a clock
  always_ff @(posedge core_clk_i) begin
    if (!readback_capture_enable_n_i) begin
      host_side_port_o <= memory_side_port_i;
    end
  end

  // --------------------------------------------------------------------
  // Output enables
  // --------------------------------------------------------------------
  // Registered so every output leaves a flop; enables lag one clock
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      memory_side_port_oe_o <= RWB_OE_RESET;
    end else begin
      memory_side_port_oe_o <= !b_drive_enable_n_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      host_side_port_oe_o <= RWB_OE_RESET;
    end else begin
      host_side_port_oe_o <= !a_drive_enable_n_i;
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  property p_full_flag;
    @(posedge core_clk_i) disable iff (!resetn_i)
      fifo_full_n_o == (fifo_count != (AW+1)'(DEPTH));
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("full flag mismatch");

  property p_write_only;
    @(posedge core_clk_i) disable iff (!resetn_i)
      !fifo_write_enable_n_i && fifo_read_enable_n_i && fifo_full_n_o
      |=> fifo_count == $past(fifo_count) + 1'h1;
  endproperty
  a_write_only: assert property (p_write_only) else $error("write not stored");

  property p_read_only;
    @(posedge core_clk_i) disable iff (!resetn_i)
      fifo_write_enable_n_i && !fifo_read_enable_n_i && fifo_count != '0
      |=> fifo_count == $past(fifo_count) - 1'h1;
  endproperty
  a_read_only: assert property (p_read_only) else $error("read did not advance");

  property p_full_discard;
    @(posedge core_clk_i) disable iff (!resetn_i)
      !fifo_write_enable_n_i && fifo_read_enable_n_i && !fifo_full_n_o
      |=> !fifo_full_n_o && $stable(memory_side_port_o);
  endproperty
  a_full_discard: assert property (p_full_discard) else $error("write to full taken");

  property p_empty_read;
    @(posedge core_clk_i) disable iff (!resetn_i)
      fifo_write_enable_n_i && !fifo_read_enable_n_i && fifo_count == '0
      |=> fifo_count == '0 && $stable(memory_side_port_o);
  endproperty
  a_empty_read: assert property (p_empty_read) else $error("empty read had effect");

  property p_reset;
    @(posedge core_clk_i)
      !resetn_i |=> fifo_count == '0 && fifo_full_n_o && memory_side_port_o == '1;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

  property p_both_empty;
    @(posedge core_clk_i) disable iff (!resetn_i)
      !fifo_write_enable_n_i && !fifo_read_enable_n_i && fifo_count == '0
      |=> fifo_count == (AW+1)'(1) && $stable(memory_side_port_o);
  endproperty
  a_both_empty: assert property (p_both_empty) else $error("empty read and write wrong");

  property p_both_full;
    @(posedge core_clk_i) disable iff (!resetn_i)
      !fifo_write_enable_n_i && !fifo_read_enable_n_i && !fifo_full_n_o
      |=> fifo_count == (AW+1)'(DEPTH - 1) && fifo_full_n_o;
  endproperty
  a_both_full: assert property (p_both_full) else $error("full read and write wrong");

  property p_capture;
    @(posedge core_clk_i) disable iff (!resetn_i)
      !readback_capture_enable_n_i |=> host_side_port_o == $past(memory_side_port_i);
  endproperty
  a_capture: assert property (p_capture) else $error("read-back not captured");

  property p_hold;
    @(posedge core_clk_i) disable iff (!resetn_i)
      readback_capture_enable_n_i |=> $stable(host_side_port_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read-back changed");

  property p_b_enable;
    @(posedge core_clk_i) disable iff (!resetn_i)
      !b_drive_enable_n_i ##1 !b_drive_enable_n_i |-> memory_side_port_oe_o;
  endproperty
  a_b_enable: assert property (p_b_enable) else $error("memory port not driven");

  property p_a_enable;
    @(posedge core_clk_i) disable iff (!resetn_i)
      a_drive_enable_n_i |=> !host_side_port_oe_o;
  endproperty
  a_a_enable: assert property (p_a_enable) else $error("host port driven when off");

  property p_occupancy;
    @(posedge core_clk_i) disable iff (!resetn_i)
      fifo_count <= (AW+1)'(DEPTH);
  endproperty
  a_occupancy: assert property (p_occupancy) else $error("occupancy above depth");

  property p_fill_order;
    @(posedge core_clk_i) disable iff (!resetn_i)
      fifo_count == '0 && !fifo_write_enable_n_i && fifo_read_enable_n_i
      ##1 fifo_write_enable_n_i && !fifo_read_enable_n_i
      |=> memory_side_port_o == $past(host_side_port_i, 2);
  endproperty
  a_fill_order: assert property (p_fill_order) else $error("word order lost");

  property p_both_mid;
    @(posedge core_clk_i) disable iff (!resetn_i)
      !fifo_write_enable_n_i && !fifo_read_enable_n_i && fifo_count != '0 && fifo_full_n_o
      |=> $stable(fifo_count);
  endproperty
  a_both_mid: assert property (p_both_mid) else $error("mid read and write wrong");

  property p_full_set;
    @(posedge core_clk_i) disable iff (!resetn_i)
      fifo_count == (AW+1)'(DEPTH - 1) && !fifo_write_enable_n_i && fifo_read_enable_n_i
      |=> !fifo_full_n_o;
  endproperty
  a_full_set: assert property (p_full_set) else $error("full flag not set");

  property p_full_release;
    @(posedge core_clk_i) disable iff (!resetn_i)
      !fifo_full_n_o && !fifo_read_enable_n_i |=> fifo_full_n_o;
  endproperty
  a_full_release: assert property (p_full_release) else $error("full not released");

  property p_full_stays;
    @(posedge core_clk_i) disable iff (!resetn_i)
      !fifo_full_n_o && fifo_read_enable_n_i
      |=> !fifo_full_n_o && fifo_count == (AW+1)'(DEPTH);
  endproperty
  a_full_stays: assert property (p_full_stays) else $error("full FIFO took a write");

  property p_write_idle;
    @(posedge core_clk_i) disable iff (!resetn_i)
      fifo_write_enable_n_i && fifo_read_enable_n_i
      |=> $stable(fifo_count) && $stable(memory_side_port_o);
  endproperty
  a_write_idle: assert property (p_write_idle) else $error("idle write path moved");

  property p_b_off;
    @(posedge core_clk_i) disable iff (!resetn_i)
      b_drive_enable_n_i |=> !memory_side_port_oe_o;
  endproperty
  a_b_off: assert property (p_b_off) else $error("memory port driven when off");

  property p_a_on;
    @(posedge core_clk_i) disable iff (!resetn_i)
      !a_drive_enable_n_i |=> host_side_port_oe_o;
  endproperty
  a_a_on: assert property (p_a_on) else $error("host port not driven");

  property p_reset_release;
    @(posedge core_clk_i)
      !resetn_i |=> !memory_side_port_oe_o && !host_side_port_oe_o;
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("port driven after reset");
endmodule

// ---- verif/rwb_mem_model.sv ----
// Memory-side partner model for the B wires
module rwb_mem_model
  import rwb_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Buffer side of the B wires
  input wire logic dut_oe_i,
  input wire logic [RWB_WIDTH-1:0] dut_data_i,
  // Resolved wire level
  output logic [RWB_WIDTH-1:0] wire_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [RWB_WIDTH-1:0] mem_word = 18'h2a5c3;
  // Fresh word each cycle, so a stale capture cannot pass
  always @(posedge clk_i) mem_word <= #1 {mem_word[16:0], mem_word[17] ^ mem_word[10]};
  // Memory keeps off the wires while the buffer drives them
  assign wire_o = dut_oe_i ? dut_data_i : mem_word;
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench for the read/write buffer
module testbench
  import rwb_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst_n = 1'h0, we_n = 1'h1, re_n = 1'h1, cap_n = 1'h1;
  logic a_en_n = 1'h1, b_en_n = 1'h1, full_n, host_oe, mem_oe;
  logic [RWB_WIDTH-1:0] host_val = '0, host_w, host_o, mem_w, mem_o;
  logic [RWB_WIDTH-1:0] fq[$];
  logic [RWB_WIDTH-1:0] exp_b = '1, exp_a = '0;
  logic a_known = 1'h0, exp_aoe = 1'h0, exp_boe = 1'h0;
  logic [39:0] notes[$];
  int num_errors = 0, checks = 0;
  int wp[4] = '{85, 15, 90, 50};
  int rp[4] = '{15, 85, 90, 50};

  initial forever #10 clk = ~clk;
  // Processor drives A only while the buffer does not
  assign host_w = host_oe ? host_o : host_val;

  rwb_top u_dut (
    .core_clk_i(clk), .resetn_i(rst_n),
    .fifo_write_enable_n_i(we_n), .fifo_read_enable_n_i(re_n), .fifo_full_n_o(full_n),
    .readback_capture_enable_n_i(cap_n),
    .a_drive_enable_n_i(a_en_n), .b_drive_enable_n_i(b_en_n),
    .host_side_port_i(host_w), .host_side_port_o(host_o), .host_side_port_oe_o(host_oe),
    .memory_side_port_i(mem_w), .memory_side_port_o(mem_o), .memory_side_port_oe_o(mem_oe)
  );
  rwb_mem_model u_mem (.clk_i(clk), .dut_oe_i(mem_oe), .dut_data_i(mem_o), .wire_o(mem_w));

  task automatic chk(input string name, input logic [RWB_WIDTH-1:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("Checks %0d, errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Driver and reference model, one cycle per call
  // --------------------------------------------------------------------
  task automatic step(input int wpc, rpc);
    logic [RWB_WIDTH-1:0] d, m;
    logic w, r, c, rs, ae, be, rd, wr;
    #1;
    rst_n = ($urandom_range(79) != 0);
    we_n = ($urandom_range(99) >= wpc);
    re_n = ($urandom_range(99) >= rpc);
    cap_n = rst_n ? 1'($urandom_range(1)) : 1'h1;
    // A stays undriven until the read-back register holds a known word
    {a_en_n, b_en_n} = ~(2'h1 << $urandom_range(2)) | {!a_known, 1'h0};
    host_val = RWB_WIDTH'($urandom);
    @(negedge clk);
    {d, m, w, r, c, rs, ae, be} = {host_w, mem_w, we_n, re_n, cap_n, rst_n, a_en_n, b_en_n};
    @(posedge clk);
    rd = !r && fq.size() > 0;
    wr = !w && fq.size() < RWB_DEPTH;
    if (!rs) begin
      fq.delete();
      exp_b = '1;
      exp_aoe = 1'h0;
      exp_boe = 1'h0;
    end else begin
      if (rd) exp_b = fq.pop_front();
      if (wr) fq.push_back(d);
      if (!c) begin
        exp_a = m;
        a_known = 1'h1;
      end
      exp_aoe = !ae;
      exp_boe = !be;
    end
    notes.push_back({a_known, exp_a, fq.size() != RWB_DEPTH, exp_b, exp_aoe, exp_boe});
  endtask

  // --------------------------------------------------------------------
  // Monitor: one note per cycle, checked once outputs settle
  // --------------------------------------------------------------------
  always @(negedge clk) begin
    logic [39:0] n;
    if (notes.size() > 0) begin
      n = notes.pop_front();
      chk("memory_side_port_o", mem_o, n[19:2]);
      chk("fifo_full_n_o", 18'(full_n), 18'(n[20]));
      if (n[39]) chk("host_side_port_o", host_o, n[38:21]);
      chk("port_oe", 18'({host_oe, mem_oe}), 18'(n[1:0]));
    end
  end

  initial begin
    void'($urandom(32'h5068));
    repeat (8) @(posedge clk);
    // Fill-heavy, drain-heavy and crowded phases reach both boundaries
    for (int p = 0; p < 8; p++) begin
      repeat (60) step(wp[p % 4], rp[p % 4]);
    end
    @(negedge clk);
    #1;
    summarize();
  end
endmodule
